// ### calc_map.vh
/*
 register offsets, field positions, reset values and arithmetic
 constants of the current and power datapath.
 assumes: included by bare name from each design file.
*/
`ifndef CALC_MAP_VH
`define CALC_MAP_VH
`define REG_CONFIGURATION 3'h0
`define REG_SHUNT_RESULT 3'h1
`define REG_BUS_RESULT 3'h2
`define REG_POWER_RESULT 3'h3
`define REG_CURRENT_RESULT 3'h4
`define REG_CALIBRATION 3'h5
`define CONFIG_RESET 16'h399f
`define CONFIG_MODE_MSB 2
`define CONFIG_MODE_LSB 0
`define MODE_POWER_DOWN 3'h0
`define MODE_DISABLE 3'h4
`define BUS_LOW_BIT_POS 3
`define BUS_READY_BIT 1
`define BUS_OVF_BIT 0
`define CAL_VOID_BIT 0
`define CURRENT_SHIFT 12
`define POWER_DIVISOR 32'h1388
`define WORD_MAX 32'h7fff
`define WORD_MIN 32'hffff8000
`define POWER_MAX 32'hffff
`define CURRENT_MAX16 16'h7fff
`define CURRENT_MIN16 16'h8000
`define POWER_MAX16 16'hffff
`define ZERO16 16'h0000
`endif

// ### word_divider.v
/*
 serial unsigned restoring divider: 32-bit dividend by 32-bit divisor,
 one quotient bit per clock, quotient truncated toward zero.
 assumes: start is a one-cycle pulse, divisor never zero.
*/
`timescale 1ns/10ps
`include "calc_map.vh"
module word_divider
#(
   parameter WIDTH = 32
)
(
   input wire sys_clk,
   input wire rst_n,
   input wire start,
   input wire [WIDTH-1:0] dividend,
   input wire [WIDTH-1:0] divisor,
   output reg [WIDTH-1:0] quotient,
   output reg done
);
   reg [WIDTH-1:0] rem;
   reg [WIDTH-1:0] shreg;
   reg [5:0] count;
   reg busy;
   wire [WIDTH:0] trial;
   assign trial = {rem, shreg[WIDTH-1]} - {1'b0, divisor};
   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rem <= {WIDTH{1'b0}};
         shreg <= {WIDTH{1'b0}};
         quotient <= {WIDTH{1'b0}};
         count <= 6'h00;
         busy <= 1'b0;
         done <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         if (start)
         begin
            rem <= {WIDTH{1'b0}};
            shreg <= dividend;
            count <= WIDTH[5:0];
            busy <= 1'b1;
         end
         else if (busy)
         begin
            // a borrow in trial means the divisor did not fit
            if (trial[WIDTH])
               rem <= {rem[WIDTH-2:0], shreg[WIDTH-1]};
            else
               rem <= trial[WIDTH-1:0];
            shreg <= {shreg[WIDTH-2:0], ~trial[WIDTH]};
            count <= count - 6'h01;
            if (count == 6'h01)
            begin
               busy <= 1'b0;
               done <= 1'b1;
               quotient <= {shreg[WIDTH-2:0], ~trial[WIDTH]};
            end
         end
      end
   end
endmodule // word_divider

// ### current_power_calc_datapath.v
/*
 current and power datapath with its register file: takes shunt and bus
 conversion results, computes current and power, serves register reads.
 assumes: register access port is a simple strobe port from the serial
 interface logic on sys_clk; conversion results arrive on sys_clk with a
 one-cycle result_valid pulse.
*/
// Operation
// - bus result left-justified, low bit at 3
// - current equals shunt times calibration over 4096
// - power equals current times bus over 5000
// - current result signed, two's complement sixteen bits
// - stored calibration is the current multiplier
// - calibration bit zero reads zero, ignores writes
// - ready flag set after math, cleared by read/mode
// - overflow flag set when current or power saturates
`timescale 1ns/10ps
`include "calc_map.vh"
module current_power_calc_datapath
(
   input wire sys_clk,
   input wire nrst,
   input wire result_valid,
   input wire [15:0] shunt_sample,
   input wire [12:0] bus_sample,
   input wire reg_write,
   input wire reg_read,
   input wire [2:0] reg_addr,
   input wire [15:0] reg_wdata,
   output reg [15:0] reg_rdata,
   output wire [15:0] configuration_out,
   output wire busy
);
   localparam ST_IDLE = 4'b0001;
   localparam ST_CUR = 4'b0010;
   localparam ST_POW = 4'b0100;
   localparam ST_DIV = 4'b1000;

   reg rst_meta;
   reg rst_n;
   reg [3:0] state;
   reg [15:0] configuration;
   reg [15:0] shunt_voltage_result;
   reg [12:0] bus_data;
   reg [15:0] power_result;
   reg [15:0] current_result;
   reg [15:0] calibration_factor;
   reg conversion_done_flag;
   reg math_overflow_flag;
   reg [15:0] next_current;
   reg next_cur_ovf;
   reg [15:0] next_power;
   reg next_pow_ovf;
   reg div_start;
   reg [31:0] div_dividend;
   wire [31:0] div_quotient;
   wire div_done;
   wire signed [31:0] cur_product;
   wire [31:0] cur_mag;
   wire [31:0] cur_trunc;
   wire signed [31:0] cur_q;
   wire [31:0] pow_product;
   wire [31:0] bus_word;
   wire mode_write;

   always @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // signed product; shift on magnitude so the division truncates to zero
   assign cur_product = $signed(shunt_voltage_result) *
                        $signed({1'b0, calibration_factor});
   assign cur_mag = cur_product[31] ? (~cur_product + 32'h1) : cur_product;
   assign cur_trunc = cur_mag >> `CURRENT_SHIFT;
   assign cur_q = cur_product[31] ? $signed(~cur_trunc + 32'h1)
                                  : $signed(cur_trunc);
   // power uses the current magnitude; no sign is applied to the quotient
   assign bus_word = {19'h00000, bus_data};
   assign pow_product = current_result[15] ?
      ({16'h0000, ~current_result + 16'h1} * bus_word) :
      ({16'h0000, current_result} * bus_word);

   always @*
   begin
      next_cur_ovf = 1'b0;
      next_current = cur_q[15:0];
      if (cur_q > $signed(`WORD_MAX))
      begin
         next_current = `CURRENT_MAX16;
         next_cur_ovf = 1'b1;
      end
      else if (cur_q < $signed(`WORD_MIN))
      begin
         next_current = `CURRENT_MIN16;
         next_cur_ovf = 1'b1;
      end
   end

   // power is reported as a magnitude; a one-step host scale of 20x
   // the current step is the host's concern
   always @*
   begin
      next_pow_ovf = 1'b0;
      next_power = div_quotient[15:0];
      if (div_quotient > `POWER_MAX)
      begin
         next_power = `POWER_MAX16;
         next_pow_ovf = 1'b1;
      end
   end

   word_divider #(.WIDTH(32)) divider
   (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .start(div_start),
      .dividend(div_dividend),
      .divisor(`POWER_DIVISOR),
      .quotient(div_quotient),
      .done(div_done)
   );

   assign mode_write = reg_write && (reg_addr == `REG_CONFIGURATION) &&
      (reg_wdata[`CONFIG_MODE_MSB:`CONFIG_MODE_LSB] != `MODE_POWER_DOWN) &&
      (reg_wdata[`CONFIG_MODE_MSB:`CONFIG_MODE_LSB] != `MODE_DISABLE);
   assign busy = !state[0];
   assign configuration_out = configuration;

   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= ST_IDLE;
         configuration <= `CONFIG_RESET;
         shunt_voltage_result <= `ZERO16;
         bus_data <= 13'h0000;
         power_result <= `ZERO16;
         current_result <= `ZERO16;
         calibration_factor <= `ZERO16;
         conversion_done_flag <= 1'b0;
         math_overflow_flag <= 1'b0;
         div_start <= 1'b0;
         div_dividend <= 32'h00000000;
      end
      else
      begin
         div_start <= 1'b0;
         if (reg_write && reg_addr == `REG_CONFIGURATION)
            configuration <= reg_wdata;
         if (reg_write && reg_addr == `REG_CALIBRATION)
            calibration_factor <= {reg_wdata[15:1], 1'b0};
         // set wins over a same-cycle clear since it is written last
         if (mode_write || (reg_read && reg_addr == `REG_BUS_RESULT))
            conversion_done_flag <= 1'b0;
         case (state)
            ST_IDLE:
            begin
               if (result_valid)
               begin
                  shunt_voltage_result <= shunt_sample;
                  bus_data <= bus_sample;
                  state <= ST_CUR;
               end
            end
            ST_CUR:
            begin
               current_result <= next_current;
               math_overflow_flag <= next_cur_ovf;
               state <= ST_POW;
            end
            ST_POW:
            begin
               div_dividend <= pow_product;
               div_start <= 1'b1;
               state <= ST_DIV;
            end
            ST_DIV:
            begin
               if (div_done)
               begin
                  power_result <= next_power;
                  math_overflow_flag <= math_overflow_flag | next_pow_ovf;
                  conversion_done_flag <= 1'b1;
                  state <= ST_IDLE;
               end
            end
            default:
               state <= ST_IDLE;
         endcase
      end
   end

   // read data registered; shunt and bus results change when a sample is accepted, current one cycle later and power when the division is done
   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         reg_rdata <= `ZERO16;
      else if (reg_read)
      begin
         case (reg_addr)
            `REG_CONFIGURATION: reg_rdata <= configuration;
            `REG_SHUNT_RESULT: reg_rdata <= shunt_voltage_result;
            `REG_BUS_RESULT: reg_rdata <= {bus_data, 1'b0,
               conversion_done_flag, math_overflow_flag};
            `REG_POWER_RESULT: reg_rdata <= power_result;
            `REG_CURRENT_RESULT: reg_rdata <= current_result;
            `REG_CALIBRATION: reg_rdata <= calibration_factor;
            default: reg_rdata <= `ZERO16;
         endcase
      end
   end
endmodule // current_power_calc_datapath

// ### calc_checker_assertions.sv
/*
 port checker for the current and power datapath.
 assumes: bound onto current_power_calc_datapath, one clock sys_clk.
*/
`timescale 1ns/10ps
module calc_checker
(
   input wire sys_clk,
   input wire nrst,
   input wire result_valid,
   input wire busy,
   input wire reg_write,
   input wire reg_read,
   input wire [2:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire [15:0] reg_rdata
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   accept_busy_a: assert property (result_valid && !busy |=> busy)
      else $error("busy did not rise after a sample");
   busy_len_a: assert property (
      result_valid && !busy |-> ##[34:38] $fell(busy))
      else $error("computation length wrong");
   ready_set_a: assert property (
      $fell(busy) && reg_read && reg_addr == 3'h2 |=> reg_rdata[1])
      else $error("ready flag missing after computation");
   ready_clear_a: assert property (
      reg_read && reg_addr == 3'h2 && !busy ##[1:4]
      reg_read && reg_addr == 3'h2 && !busy |=> !reg_rdata[1])
      else $error("ready flag not cleared by read");
   cal_void_a: assert property (
      reg_read && reg_addr == 3'h5 |=> !reg_rdata[0])
      else $error("calibration bit zero reads one");
   cal_readback_a: assert property (
      reg_write && reg_addr == 3'h5 ##1 reg_read && reg_addr == 3'h5
      |=> reg_rdata == ($past(reg_wdata, 2) & 16'hfffe))
      else $error("calibration readback wrong");
   bus_bit2_a: assert property (
      reg_read && reg_addr == 3'h2 |=> !reg_rdata[2])
      else $error("bus register bit two set");
   rdata_hold_a: assert property (!reg_read |=> $stable(reg_rdata))
      else $error("read data changed without a read");
   cover property (result_valid && !busy);
   cover property ($fell(busy) && reg_read && reg_addr == 3'h2);
   cover property (reg_write && reg_addr == 3'h0);
endmodule // calc_checker
bind current_power_calc_datapath calc_checker calc_checker_i (
   .sys_clk(sys_clk), .nrst(nrst), .result_valid(result_valid),
   .busy(busy), .reg_write(reg_write), .reg_read(reg_read),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

// ### host_port_model.sv
/*
 host side of the register port: one-cycle write and read strobes.
 assumes: tasks are entered just after a rising edge of sys_clk.
*/
`timescale 1ns/10ps
module host_port_model
(
   input wire sys_clk,
   input wire [15:0] reg_rdata,
   output reg reg_write,
   output reg reg_read,
   output reg [2:0] reg_addr,
   output reg [15:0] reg_wdata
);
   initial
   begin
      reg_write = 1'b0;
      reg_read = 1'b0;
      reg_addr = 3'h0;
      reg_wdata = 16'h0000;
   end
   // host programs the multiplier itself
   task write_reg(input [2:0] a, input [15:0] v);
   begin
      reg_write = 1'b1;
      reg_addr = a;
      reg_wdata = v;
      @(posedge sys_clk);
      #1;
      reg_write = 1'b0;
      // released data shows the inverse so stale values never match
      reg_wdata = ~v;
   end
   endtask
   task read_reg(input [2:0] a, output [15:0] v);
   begin
      reg_read = 1'b1;
      reg_addr = a;
      @(posedge sys_clk);
      #1;
      reg_read = 1'b0;
      @(posedge sys_clk);
      #1;
      v = reg_rdata;
   end
   endtask
endmodule // host_port_model

// ### tb_top.sv
/*
 self-checking bench: table and random conversions, register reads.
 assumes: design and host model compiled first.
*/
`timescale 1ns/10ps
module tb_top;
   reg sys_clk, nrst, result_valid;
   reg [15:0] shunt_sample, d, cal, sh;
   reg [12:0] bus_sample, bv;
   reg [32:0] e;
   wire reg_write, reg_read, busy;
   wire [2:0] reg_addr;
   wire [15:0] reg_wdata, reg_rdata, configuration_out;
   integer fail_count, compares, seed, i, k;
   current_power_calc_datapath current_power_calc_datapath_i (
      .sys_clk(sys_clk), .nrst(nrst), .result_valid(result_valid),
      .shunt_sample(shunt_sample), .bus_sample(bus_sample),
      .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .configuration_out(configuration_out), .busy(busy));
   host_port_model host_port_model_i (.sys_clk(sys_clk),
      .reg_rdata(reg_rdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata));
   initial
   begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   // returns {overflow, power, current}
   function [32:0] expect_calc(input [15:0] c, input [15:0] s,
      input [12:0] b);
      integer q, p;
      reg o;
   begin
      q = $signed(s) * $signed({16'h0000, c & 16'hfffe}) / 4096;
      o = (q > 32767) || (q < -32768);
      q = (q > 32767) ? 32767 : ((q < -32768) ? -32768 : q);
      p = ((q < 0) ? -q : q) * b / 5000;
      o = o || (p > 65535);
      p = (p > 65535) ? 65535 : p;
      expect_calc = {o, p[15:0], q[15:0]};
   end
   endfunction
   task check(input [127:0] name, input [15:0] exp, input [15:0] got);
   begin
      compares = compares + 1;
      if (got !== exp)
      begin
         $display("Error %0s expected %h seen %h", name, exp, got);
         fail_count = fail_count + 1;
      end
   end
   endtask
   // second cycle arrives while busy and must be dropped
   task convert(input [15:0] s, input [12:0] b);
   begin
      result_valid = 1'b1;
      shunt_sample = s;
      bus_sample = b;
      @(posedge sys_clk);
      #1;
      shunt_sample = ~s;
      bus_sample = ~b;
      @(posedge sys_clk);
      #1;
      result_valid = 1'b0;
      k = 0;
      while (busy !== 1'b0 && k < 60)
      begin
         @(posedge sys_clk);
         #1;
         k = k + 1;
      end
      // a computation that never ends would hold busy high here
      check("busy_end", 16'h0000, {15'h0000, busy});
   end
   endtask
   task report_and_stop;
   begin
      $display("fail_count %0d compares %0d", fail_count, compares);
      if (fail_count == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   end
   endtask
   initial
   begin
      #300000;
      fail_count = fail_count + 1;
      report_and_stop;
   end
   initial
   begin
      seed = 32'h5a74acc6;
      fail_count = 0;
      compares = 0;
      nrst = 1'b0;
      result_valid = 1'b0;
      shunt_sample = 16'h0000;
      bus_sample = 13'h0000;
      repeat (2) @(posedge sys_clk);
      #1 nrst = 1'b1;
      repeat (3) @(posedge sys_clk);
      #1;
      host_port_model_i.read_reg(3'h0, d);
      check("config", 16'h399f, d);
      host_port_model_i.read_reg(3'h6, d);
      check("unmapped", 16'h0000, d);
      for (i = 0; i < 14; i = i + 1)
      begin
         cal = $random(seed);
         sh = $random(seed);
         bv = $random(seed);
         if (i == 0)
            {cal, sh, bv} = {16'h5000, 16'h07d0, 13'h0bb3};
         if (i == 1)
            {cal, sh, bv} = {16'hffff, 16'h7fff, 13'h1fff};
         if (i == 2)
            {cal, sh, bv} = {16'hffff, 16'h8000, 13'h1fff};
         e = expect_calc(cal, sh, bv);
         host_port_model_i.write_reg(3'h5, cal);
         host_port_model_i.read_reg(3'h5, d);
         check("calib", cal & 16'hfffe, d);
         convert(sh, bv);
         // bus read first: it lands on the edge where busy falls
         host_port_model_i.read_reg(3'h2, d);
         check("bus", {bv, 2'b01, e[32]}, d);
         host_port_model_i.read_reg(3'h2, d);
         check("bus_again", {bv, 2'b00, e[32]}, d);
         host_port_model_i.read_reg(3'h4, d);
         check("current", e[15:0], d);
         // one power step is twenty current steps to the host
         host_port_model_i.read_reg(3'h3, d);
         check("power", e[31:16], d);
         host_port_model_i.read_reg(3'h1, d);
         check("shunt", sh, d);
      end
      convert(sh, bv);
      host_port_model_i.write_reg(3'h0, 16'h399e);
      check("cfg_out", 16'h399e, configuration_out);
      host_port_model_i.read_reg(3'h2, d);
      check("mode_clr", {bv, 2'b00, e[32]}, d);
      report_and_stop;
   end
endmodule // tb_top
